// File: core/fsp_cfg.svh
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// ----------------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------------
`define FSP_ADDR_W        12
`define FSP_DATA_W        24
`define FSP_RAM_DEPTH     128
`define FSP_RAM_AW        7
`define FSP_SEMA_N        3

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define FSP_OFS_STAGE_A   12'h000
`define FSP_OFS_STAGE_B   12'h004
`define FSP_OFS_HOLD_A    12'h008
`define FSP_OFS_HOLD_B    12'h00C
`define FSP_OFS_COHER     12'h010
`define FSP_OFS_RAM_OWN   12'h014
`define FSP_OFS_SEMA      12'h018
`define FSP_OFS_INTR      12'h01C
`define FSP_OFS_DMA       12'h020
`define FSP_OFS_STATUS    12'h024

// RAM windows: address bits 11:9 select the page, bits 8:2 the word.
`define FSP_RAM_A_PAGE    3'h1
`define FSP_RAM_B_PAGE    3'h2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FSP_COHER_STG_POS   0
`define FSP_COHER_HLD_POS   4
`define FSP_SEMA_MASK_POS   4
`define FSP_INTR_SEM_POS    2
`define FSP_DMA_EN_POS      2
`define FSP_ST_SEM_POS      2
`define FSP_ST_STG_POS      5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FSP_COHER_RST     8'hAA
`define FSP_RAM_OWN_RST   2'h0
`define FSP_INTR_RST      5'h00
`define FSP_DMA_RST       4'h0
`define FSP_SEMA_RST      3'h0

`endif

// File: core/fsp_pkg.sv
`include "fsp_cfg.svh"

package fsp_pkg;
    typedef logic [`FSP_DATA_W-1:0]  fsp_word_t;
    typedef logic [1:0]              fsp_lane_t;
    typedef logic [`FSP_SEMA_N-1:0]  fsp_sema_t;
    typedef logic [`FSP_RAM_AW-1:0]  fsp_ram_addr_t;
endpackage : fsp_pkg

// File: core/fsp_stage_if.sv
`timescale 1ns/1ns
`default_nettype none

interface fsp_stage_if;
    logic              wr;
    logic [2:0]        be;
    fsp_pkg::fsp_word_t wdata;
    fsp_pkg::fsp_lane_t key;
    logic              take;
    fsp_pkg::fsp_word_t data;
    logic              valid;

    modport ctrl  (output wr, be, wdata, key, take, input data, valid);
    modport stage (input wr, be, wdata, key, take, output data, valid);
endinterface : fsp_stage_if

`default_nettype wire

// File: core/fsp_stage.sv
`timescale 1ns/1ns
`default_nettype none

module fsp_stage (
    // Clock and reset
    input wire logic    clk_i,
    input wire logic    arst_n_i,
    // Bus and engine side
    fsp_stage_if.stage  port_if
);
    fsp_pkg::fsp_word_t back;
    fsp_pkg::fsp_word_t merged;
    fsp_pkg::fsp_lane_t key_lane;
    logic               key_done;

    // Lane code 3 has no byte behind it, so it acts as the top lane.
    assign key_lane = (port_if.key == 2'h3) ? 2'h2 : port_if.key;
    assign key_done = port_if.wr && port_if.be[key_lane];

    always_comb begin
        merged = back;
        for (int b = 0; b < 3; b++) begin
            if (port_if.wr && port_if.be[b]) begin
                merged[b*8 +: 8] = port_if.wdata[b*8 +: 8];
            end
        end
    end

    // RL2: bus-side buffer.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            back <= '0;
        end else begin
            back <= merged;
        end
    end

    // RL8: publish on key byte.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_if.data <= '0;
        end else if (key_done) begin
            port_if.data <= merged;
        end
    end

    // RL7: consume clears valid.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_if.valid <= 1'b0;
        end else if (key_done) begin
            port_if.valid <= 1'b1;
        end else if (port_if.take) begin
            port_if.valid <= 1'b0;
        end
    end

    a_key_sets_valid: assert property ( // RL8
        @(posedge clk_i) disable iff (!arst_n_i) key_done |=> port_if.valid)
        else $error("Key byte write did not flag the staged value.");
    a_take_clears: assert property ( // RL7
        @(posedge clk_i) disable iff (!arst_n_i)
        port_if.take && !key_done |=> !port_if.valid)
        else $error("Engine read left the staging flag set.");
    a_partial_hidden: assert property ( // RL8
        @(posedge clk_i) disable iff (!arst_n_i) !key_done |=> $stable(port_if.data))
        else $error("Staged value changed without a key byte write.");
endmodule : fsp_stage

`default_nettype wire

// File: core/fsp_staging_port.sv
// Behaviour
// RL1: two staging and two holding 24-bit registers.
// RL2: each register double buffered, seen as one.
// RL3: engine read delivers sample or stalls waiting.
// RL4: engine read raises no bus, interrupt, DMA.
// RL5: staging full flags offered as branch conditions.
// RL6: address bit 0 picks staging A or B.
// RL7: engine read clears that staging valid flag.
// RL8: staging valid only after key byte write.
// RL9: holding frozen until its key byte read.
// RL10: coherency register selects each key byte.
// RL11: software accesses key byte last.
// RL12: engine bus write picks holding A or B.
// RL13: holding registers read only, polled or DMA.
// RL14: holding update pends interrupt, shown in status.
// RL15: two independent 128x24 data RAMs.
// RL16: per-RAM ownership bit; engine stalls when needed.
// RL17: semaphore changes may raise an interrupt.
// RL18: each channel at most 1 Msps.
// RL19: two DMA requests, holding or semaphore sourced.
// RL20: reset clears flags, engine owns both RAMs.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "fsp_cfg.svh"

module fsp_staging_port #(
    parameter int RAM_DEPTH = `FSP_RAM_DEPTH
) (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             arst_n_i,
    // Register port
    input  wire logic [`FSP_ADDR_W-1:0]           bus_addr_i,
    input  wire logic [3:0]                       bus_be_i,
    input  wire logic [31:0]                      bus_wdata_i,
    input  wire logic                             bus_wr_i,
    input  wire logic                             bus_rd_i,
    output logic      [31:0]                      bus_rdata_o,
    // Engine sample transfer
    input  wire logic                             eng_rd_i,
    input  wire logic                             eng_wr_i,
    input  wire logic                             eng_addr0_i,
    input  wire fsp_pkg::fsp_word_t               eng_wdata_i,
    output fsp_pkg::fsp_word_t                    eng_rdata_o,
    output logic                                  eng_rvalid_o,
    output logic                                  eng_stall_o,
    output logic      [1:0]                       eng_stage_full_o,
    // Engine data RAM access
    input  wire logic [1:0]                       eng_ram_need_i,
    input  wire logic [1:0][`FSP_RAM_AW-1:0]      eng_ram_addr_i,
    input  wire logic [1:0]                       eng_ram_we_i,
    input  wire logic [1:0][`FSP_DATA_W-1:0]      eng_ram_wdata_i,
    output logic      [1:0][`FSP_DATA_W-1:0]      eng_ram_rdata_o,
    // Engine semaphore commands
    input  wire logic                             eng_sem_set_i,
    input  wire logic                             eng_sem_clr_i,
    input  wire fsp_pkg::fsp_sema_t               eng_sem_bits_i,
    // System requests
    output logic                                  intr_o,
    output logic      [1:0]                       dma_req_o
);
    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0]                 coher;
    logic [1:0]                 ram_owner;
    logic [4:0]                 intr_ctrl;
    logic [3:0]                 dma_ctrl;
    fsp_pkg::fsp_sema_t         sem;
    fsp_pkg::fsp_sema_t         next_sem;
    fsp_pkg::fsp_sema_t         sem_pend;
    logic [1:0]                 stage_valid;
    fsp_pkg::fsp_word_t         stage_data [2];
    fsp_pkg::fsp_word_t         hold_front [2];
    fsp_pkg::fsp_word_t         hold_back  [2];
    logic [1:0]                 hold_full;
    logic [1:0]                 hold_lock;
    logic [1:0]                 hold_pend;
    logic [1:0]                 hold_xfer;
    logic [1:0]                 hold_key_rd;
    logic [1:0]                 ram_stall_need;
    logic                       stage_wait;
    logic                       wr_coher;
    logic                       wr_owner;
    logic                       wr_sema;
    logic                       wr_intr;
    logic                       wr_dma;
    logic                       wr_status;
    logic [31:0]                next_rdata;
    logic [`FSP_DATA_W-1:0]     ram_mem [2][RAM_DEPTH];
    logic [`FSP_RAM_AW-1:0]     bus_idx;

    assign wr_coher  = bus_wr_i && (bus_addr_i == `FSP_OFS_COHER);
    assign wr_owner  = bus_wr_i && (bus_addr_i == `FSP_OFS_RAM_OWN);
    assign wr_sema   = bus_wr_i && (bus_addr_i == `FSP_OFS_SEMA);
    assign wr_intr   = bus_wr_i && (bus_addr_i == `FSP_OFS_INTR);
    assign wr_dma    = bus_wr_i && (bus_addr_i == `FSP_OFS_DMA);
    assign wr_status = bus_wr_i && (bus_addr_i == `FSP_OFS_STATUS);
    assign bus_idx   = bus_addr_i[8:2];

    // RL10: key byte selection.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            coher <= `FSP_COHER_RST;
        end else if (wr_coher) begin
            coher <= bus_wdata_i[7:0];
        end
    end

    // RL20: engine owns RAMs after reset.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ram_owner <= `FSP_RAM_OWN_RST;
        end else if (wr_owner) begin
            ram_owner <= bus_wdata_i[1:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            intr_ctrl <= `FSP_INTR_RST;
            dma_ctrl  <= `FSP_DMA_RST;
        end else begin
            if (wr_intr) begin
                intr_ctrl <= bus_wdata_i[4:0];
            end
            if (wr_dma) begin
                dma_ctrl <= bus_wdata_i[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Staging registers
    // ------------------------------------------------------------------
    // RL1: paired registers.
    fsp_stage_if stg_if[2] ();

    for (genvar i = 0; i < 2; i++) begin : g_stage
        assign stg_if[i].wr    = bus_wr_i && (bus_addr_i == 12'(`FSP_OFS_STAGE_A + 4*i));
        assign stg_if[i].be    = bus_be_i[2:0];
        assign stg_if[i].wdata = bus_wdata_i[23:0];
        assign stg_if[i].key   = coher[`FSP_COHER_STG_POS + 2*i +: 2];
        // RL6: address bit selects channel.
        assign stg_if[i].take  = eng_rd_i && (eng_addr0_i == 1'(i)) && stg_if[i].valid;
        assign stage_valid[i]  = stg_if[i].valid;
        assign stage_data[i]   = stg_if[i].data;

        fsp_stage u_stage (
            .clk_i    (clk_i),
            .arst_n_i (arst_n_i),
            .port_if  (stg_if[i])
        );
    end

    // RL5: full flags for branching.
    assign eng_stage_full_o = stage_valid;

    // RL16: stall while a needed RAM is on the bus.
    assign ram_stall_need = eng_ram_need_i & ram_owner;
    // RL3: stall until the sample arrives.
    assign stage_wait     = eng_rd_i && !stage_valid[eng_addr0_i];
    assign eng_stall_o    = stage_wait || (|ram_stall_need);

    // RL4: a read touches only the staging flag and the data path.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            eng_rdata_o  <= '0;
            eng_rvalid_o <= 1'b0;
        end else begin
            eng_rvalid_o <= eng_rd_i && stage_valid[eng_addr0_i];
            if (eng_rd_i && stage_valid[eng_addr0_i]) begin
                eng_rdata_o <= stage_data[eng_addr0_i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_hold
        logic       rd_here;
        logic [1:0] key_lane;
        logic       part_rd;

        assign rd_here        = bus_rd_i && (bus_addr_i == 12'(`FSP_OFS_HOLD_A + 4*i));
        assign key_lane       = (coher[`FSP_COHER_HLD_POS + 2*i +: 2] == 2'h3) ? 2'h2
                                : coher[`FSP_COHER_HLD_POS + 2*i +: 2];
        assign hold_key_rd[i] = rd_here && bus_be_i[key_lane];
        assign part_rd        = rd_here && !hold_key_rd[i] && (|bus_be_i[2:0]);
        // RL9: no transfer while a read is open.
        assign hold_xfer[i]   = hold_full[i] && !hold_lock[i] && !part_rd;

        // RL12: engine write lands in the back buffer.
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                hold_back[i] <= '0;
                hold_full[i] <= 1'b0;
            end else if (eng_wr_i && (eng_addr0_i == 1'(i))) begin
                hold_back[i] <= eng_wdata_i;
                hold_full[i] <= 1'b1;
            end else if (hold_xfer[i]) begin
                hold_full[i] <= 1'b0;
            end
        end

        // RL9: lock until key byte read.
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                hold_lock[i] <= 1'b0;
            end else if (part_rd) begin
                hold_lock[i] <= 1'b1;
            end else if (hold_key_rd[i]) begin
                hold_lock[i] <= 1'b0;
            end
        end

        // RL2: front copy seen by the bus.
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                hold_front[i] <= '0;
            end else if (hold_xfer[i]) begin
                hold_front[i] <= hold_back[i];
            end
        end

        // RL14: update pends; a same-cycle update beats the clear.
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                hold_pend[i] <= 1'b0;
            end else if (hold_xfer[i]) begin
                hold_pend[i] <= 1'b1;
            end else if (hold_key_rd[i]) begin
                hold_pend[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Semaphores
    // ------------------------------------------------------------------
    always_comb begin
        next_sem = sem;
        if (wr_sema) begin
            next_sem = (next_sem & ~bus_wdata_i[`FSP_SEMA_MASK_POS +: 3])
                     | (bus_wdata_i[2:0] & bus_wdata_i[`FSP_SEMA_MASK_POS +: 3]);
        end
        if (eng_sem_clr_i) begin
            next_sem = next_sem & ~eng_sem_bits_i;
        end
        if (eng_sem_set_i) begin
            next_sem = next_sem | eng_sem_bits_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sem <= `FSP_SEMA_RST;
        end else begin
            sem <= next_sem;
        end
    end

    // RL17: any enabled change pends; set wins over write-one clear.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sem_pend <= '0;
        end else begin
            sem_pend <= (sem_pend & ~(wr_status ? bus_wdata_i[`FSP_ST_SEM_POS +: 3] : 3'h0))
                      | ((next_sem ^ sem) & intr_ctrl[`FSP_INTR_SEM_POS +: 3]);
        end
    end

    // RL14: hold pending feeds interrupt when enabled.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            intr_o <= 1'b0;
        end else begin
            intr_o <= (|(hold_pend & intr_ctrl[1:0])) || (|sem_pend);
        end
    end

    // RL19: each request sourced from holding or semaphore.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dma_req_o <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                dma_req_o[i] <= dma_ctrl[`FSP_DMA_EN_POS + i]
                                && (dma_ctrl[i] ? hold_pend[i] : sem[i]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Data RAMs
    // ------------------------------------------------------------------
    // RL15: two separate memories.
    for (genvar i = 0; i < 2; i++) begin : g_ram
        logic bus_page;
        assign bus_page = (bus_addr_i[11:9] == ((i == 0) ? `FSP_RAM_A_PAGE : `FSP_RAM_B_PAGE));

        // RL16: the owner alone may write.
        always_ff @(posedge clk_i) begin
            if (ram_owner[i]) begin
                if (bus_wr_i && bus_page) begin
                    ram_mem[i][bus_idx] <= bus_wdata_i[23:0];
                end
            end else if (eng_ram_we_i[i]) begin
                ram_mem[i][eng_ram_addr_i[i]] <= eng_ram_wdata_i[i];
            end
        end

        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                eng_ram_rdata_o[i] <= '0;
            end else begin
                eng_ram_rdata_o[i] <= ram_mem[i][eng_ram_addr_i[i]];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped addresses and RAMs held by the engine read as zero.
    always_comb begin
        next_rdata = 32'h0;
        if (bus_addr_i == `FSP_OFS_STAGE_A) begin
            next_rdata = {8'h00, stage_data[0]};
        end else if (bus_addr_i == `FSP_OFS_STAGE_B) begin
            next_rdata = {8'h00, stage_data[1]};
        end else if (bus_addr_i == `FSP_OFS_HOLD_A) begin
            next_rdata = {8'h00, hold_front[0]};
        end else if (bus_addr_i == `FSP_OFS_HOLD_B) begin
            next_rdata = {8'h00, hold_front[1]};
        end else if (bus_addr_i == `FSP_OFS_COHER) begin
            next_rdata = {24'h0, coher};
        end else if (bus_addr_i == `FSP_OFS_RAM_OWN) begin
            next_rdata = {30'h0, ram_owner};
        end else if (bus_addr_i == `FSP_OFS_SEMA) begin
            next_rdata = {29'h0, sem};
        end else if (bus_addr_i == `FSP_OFS_INTR) begin
            next_rdata = {27'h0, intr_ctrl};
        end else if (bus_addr_i == `FSP_OFS_DMA) begin
            next_rdata = {28'h0, dma_ctrl};
        end else if (bus_addr_i == `FSP_OFS_STATUS) begin
            next_rdata = {25'h0, stage_valid, sem_pend, hold_pend};
        end else if (bus_addr_i[11:9] == `FSP_RAM_A_PAGE && ram_owner[0]) begin
            next_rdata = {8'h00, ram_mem[0][bus_idx]};
        end else if (bus_addr_i[11:9] == `FSP_RAM_B_PAGE && ram_owner[1]) begin
            next_rdata = {8'h00, ram_mem[1][bus_idx]};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_rdata_o <= 32'h0;
        end else if (bus_rd_i) begin
            bus_rdata_o <= next_rdata;
        end else begin
            bus_rdata_o <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_stall_empty: assert property ( // RL3
        eng_rd_i && !stage_valid[eng_addr0_i] |-> eng_stall_o ##1 !eng_rvalid_o)
        else $error("Engine read of an empty stage did not stall.");
    a_read_delivers: assert property ( // RL6
        eng_rd_i && !eng_addr0_i && stage_valid[0]
        |=> eng_rvalid_o && eng_rdata_o == $past(stage_data[0]))
        else $error("Engine read of stage A returned wrong data.");
    a_hold_locked: assert property ( // RL9
        hold_lock[0] |=> $stable(hold_front[0]))
        else $error("Holding A changed during an open read.");
    a_pend_on_update: assert property ( // RL14
        hold_xfer[1] |=> hold_pend[1] && hold_front[1] == $past(hold_back[1]))
        else $error("Holding B update did not pend.");
    a_ram_stall: assert property ( // RL16
        (eng_ram_need_i[0] && ram_owner[0]) |-> eng_stall_o)
        else $error("Engine ran while RAM A was on the bus.");
    a_sem_intr: assert property ( // RL17
        (sem[0] != next_sem[0]) && intr_ctrl[`FSP_INTR_SEM_POS] |=> sem_pend[0] ##1 intr_o)
        else $error("Semaphore change raised no interrupt.");
endmodule : fsp_staging_port

`default_nettype wire

// File: verification/fsp_engine_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Engine sequencer model
// ----------------------------------------------------------------------
module fsp_engine_model (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    // Bench commands
    input  wire logic               rd_go_i,
    input  wire logic               wr_go_i,
    input  wire logic               sel_i,
    input  wire fsp_pkg::fsp_word_t wdata_i,
    // Engine side of the port
    input  wire logic               stall_i,
    output logic                    rd_o,
    output logic                    wr_o,
    output logic                    addr0_o,
    output fsp_pkg::fsp_word_t      wdata_o
);
    // hold while stalled
    // Read stays up through a stall: a late sample is never missed.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_o <= 1'b0;
            wr_o <= 1'b0;
        end else begin
            wr_o <= wr_go_i;
            if (rd_go_i) begin
                rd_o <= 1'b1;
            end else if (rd_o && !stall_i) begin
                rd_o <= 1'b0;
            end
        end
    end

    // Idle write data toggles so a stale value cannot pass for a fresh one.
    always_ff @(posedge clk_i) begin
        if (rd_go_i || wr_go_i) begin
            addr0_o <= sel_i;
            wdata_o <= wdata_i;
        end else begin
            wdata_o <= ~wdata_o;
        end
    end
endmodule : fsp_engine_model

`default_nettype wire

// File: verification/fsp_staging_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

module fsp_staging_port_tb;
    logic clk_i = 1'b0, arst_n_i = 1'b0, bus_wr_i = 1'b0, bus_rd_i = 1'b0;
    logic eng_rd_i, eng_wr_i, eng_addr0_i, eng_rvalid_o, eng_stall_o, intr_o;
    logic rd_go = 1'b0, wr_go = 1'b0, sel = 1'b0;
    logic eng_sem_set_i = 1'b0, eng_sem_clr_i = 1'b0;
    logic [11:0] bus_addr_i = 12'h000;
    logic [3:0] bus_be_i = 4'h0;
    logic [31:0] bus_wdata_i = 32'h0, bus_rdata_o;
    logic [1:0] eng_stage_full_o, dma_req_o, eng_ram_need_i = 2'h0, eng_ram_we_i = 2'h3;
    logic [1:0][6:0] eng_ram_addr_i = '0;
    logic [1:0][23:0] eng_ram_wdata_i = '0, eng_ram_rdata_o;
    fsp_pkg::fsp_word_t eng_wdata_i, eng_rdata_o, wd = '0;
    fsp_pkg::fsp_sema_t eng_sem_bits_i = '0;
    int n_fail = 0, comparisons = 0, cyc = 0;

    always #20 clk_i = ~clk_i;

    fsp_staging_port dut_u (.clk_i, .arst_n_i, .bus_addr_i, .bus_be_i, .bus_wdata_i,
        .bus_wr_i, .bus_rd_i, .bus_rdata_o, .eng_rd_i, .eng_wr_i, .eng_addr0_i,
        .eng_wdata_i, .eng_rdata_o, .eng_rvalid_o, .eng_stall_o, .eng_stage_full_o,
        .eng_ram_need_i, .eng_ram_addr_i, .eng_ram_we_i, .eng_ram_wdata_i,
        .eng_ram_rdata_o, .eng_sem_set_i, .eng_sem_clr_i, .eng_sem_bits_i, .intr_o,
        .dma_req_o);
    fsp_engine_model eng_u (.clk_i, .arst_n_i, .rd_go_i(rd_go), .wr_go_i(wr_go),
        .sel_i(sel), .wdata_i(wd), .stall_i(eng_stall_o), .rd_o(eng_rd_i),
        .wr_o(eng_wr_i), .addr0_o(eng_addr0_i), .wdata_o(eng_wdata_i));

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bwr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_i);
        bus_addr_i <= a;
        bus_be_i <= be;
        bus_wdata_i <= d;
        bus_wr_i <= 1'b1;
        @(posedge clk_i);
        bus_wr_i <= 1'b0;
        #1;
    endtask : bwr

    task automatic brd(input logic [11:0] a, input logic [3:0] be, output logic [31:0] d);
        @(posedge clk_i);
        bus_addr_i <= a;
        bus_be_i <= be;
        bus_rd_i <= 1'b1;
        @(posedge clk_i);
        bus_rd_i <= 1'b0;
        #1 d = bus_rdata_o;
    endtask : brd

    task automatic eng(input logic rd, input logic s, input fsp_pkg::fsp_word_t d);
        @(posedge clk_i);
        rd_go <= rd;
        wr_go <= !rd;
        sel <= s;
        wd <= d;
        @(posedge clk_i);
        rd_go <= 1'b0;
        wr_go <= 1'b0;
    endtask : eng

    task automatic wait_rv(input fsp_pkg::fsp_word_t exp);
        int k = 0;
        do begin
            @(posedge clk_i);
            #1 k++;
        end while (eng_rvalid_o !== 1'b1 && k < 20);
        chk({eng_rvalid_o, eng_rdata_o}, {1'b1, exp});
    endtask : wait_rv

    // Lane that completes a field; code 3 acts as lane 2.
    function automatic logic [3:0] key_be(input logic [7:0] c, input logic f);
        logic [1:0] l;
        l = f ? c[3:2] : c[1:0];
        return (l == 2'h3) ? 4'h4 : (4'h1 << l);
    endfunction : key_be

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        logic [31:0] r;
        fsp_pkg::fsp_word_t va, vb;
        logic [7:0] coh;
        void'($urandom(7));
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        eng_ram_addr_i <= {7'($urandom), 7'h01};
        eng_ram_wdata_i <= {24'($urandom), 24'($urandom)};
        #1 chk({30'h0, eng_stage_full_o}, 32'h0);
        brd(12'h010, 4'hF, r); chk(r, 32'h0000_00AA);
        brd(12'h014, 4'hF, r); chk(r, 32'h0);
        brd(12'h0FC, 4'hF, r); chk(r, 32'h0);
        for (int i = 0; i < 4; i++) begin
            va = 24'($urandom);
            vb = 24'($urandom);
            coh = 8'hA0 | 8'($urandom_range(0, 15));
            bwr(12'h010, 4'h1, {24'h0, coh});
            bwr(12'h004, 4'h7 & ~key_be(coh, 1'b1), {8'h0, vb});
            chk({30'h0, eng_stage_full_o}, 32'h0);
            bwr(12'h004, key_be(coh, 1'b1), {8'h0, vb});
            bwr(12'h000, 4'h7, {8'h0, va});
            chk({30'h0, eng_stage_full_o}, 32'h3);
            eng(1'b1, 1'b1, '0); wait_rv(vb);
            eng(1'b1, 1'b0, '0); wait_rv(va);
            chk({30'h0, eng_stage_full_o}, 32'h0);
        end
        eng(1'b1, 1'b0, '0);
        repeat (3) @(posedge clk_i);
        #1 chk({29'h0, eng_stall_o, intr_o, dma_req_o}, 32'h8);
        bwr(12'h000, 4'h7, {8'h0, va}); wait_rv(va);
        bwr(12'h010, 4'h1, 32'hAA);
        bwr(12'h01C, 4'h1, 32'h5);
        bwr(12'h020, 4'h1, 32'h5);
        eng(1'b0, 1'b0, vb);
        repeat (4) @(posedge clk_i);
        brd(12'h024, 4'hF, r); chk({r[0], intr_o, dma_req_o}, 4'hD);
        brd(12'h008, 4'h3, r); chk(r[15:0], vb[15:0]);
        eng(1'b0, 1'b0, va);
        repeat (4) @(posedge clk_i);
        bwr(12'h008, 4'h7, 32'h0);
        brd(12'h008, 4'h4, r); chk(r[23:16], vb[23:16]);
        repeat (4) @(posedge clk_i);
        brd(12'h008, 4'hF, r); chk(r[23:0], va);
        eng(1'b0, 1'b1, vb);
        repeat (4) @(posedge clk_i);
        brd(12'h00C, 4'hF, r); chk(r[23:0], vb);
        bwr(12'h204, 4'hF, {8'h0, va});
        brd(12'h204, 4'hF, r); chk(r, 32'h0);
        bwr(12'h014, 4'h1, 32'h1);
        bwr(12'h204, 4'hF, {8'h0, va});
        brd(12'h204, 4'hF, r); chk(r, {8'h0, va});
        brd(12'h404, 4'hF, r); chk(r, 32'h0);
        bwr(12'h018, 4'h1, 32'h11);
        @(posedge clk_i) eng_ram_need_i <= 2'h1;
        #1 chk({intr_o, eng_stall_o, eng_ram_rdata_o[0]}, {2'h3, va});
        test_done();
    end
endmodule : fsp_staging_port_tb

`default_nettype wire
